// *** hw/fpx_params.svh ***
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH

// register byte offsets on the apb window
`define FPX_OFF_STATUS 8'h00
`define FPX_OFF_TRAPS 8'h04
`define FPX_OFF_OPS 8'h08
`define FPX_OFF_LAST 8'h0C
`define FPX_OFF_CNT_LO 8'h10
`define FPX_OFF_CNT_HI 8'h14

// status register field positions
`define FPX_TEM_HI 27
`define FPX_TEM_LO 23
`define FPX_FTT_HI 16
`define FPX_FTT_LO 14
`define FPX_AEXC_HI 9
`define FPX_AEXC_LO 5
`define FPX_CEXC_HI 4
`define FPX_CEXC_LO 0

// bit order inside every five-bit exception field
`define FPX_NV_BIT 4
`define FPX_OF_BIT 3
`define FPX_UF_BIT 2
`define FPX_DZ_BIT 1
`define FPX_NX_BIT 0

// reset values
`define FPX_TEM_RST 5'h00
`define FPX_AEXC_RST 5'h00
`define FPX_CEXC_RST 5'h00
`define FPX_FTT_RST 3'h0
`define FPX_CNT_RST 16'h0000
`define FPX_EVT_RST 8'h00

// trap type codes
`define FPX_FTT_NONE 3'h0
`define FPX_FTT_IEEE 3'h1

// counter limits
`define FPX_CNT_MAX 16'hFFFF
`define FPX_EVT_MAX 8'hFF

`endif

// *** hw/fpx_pkg.sv ***
package fpx_pkg;

	typedef logic [4:0] fpx_exc_t;
	typedef logic [2:0] fpx_ftt_t;
	typedef logic [15:0] fpx_cnt_t;
	typedef logic [7:0] fpx_evt_t;

	typedef enum logic [2:0] {
		SEL_STATUS,
		SEL_TRAPS,
		SEL_OPS,
		SEL_LAST,
		SEL_CNT_LO,
		SEL_CNT_HI,
		SEL_NONE
	} fpx_sel_t;

endpackage

// *** hw/fpx_cond_eval.sv ***
`timescale 1ns/1ps
`include "fpx_params.svh"

// raw ieee conditions of one completed operation
module fpx_cond_eval (
	input wire logic cond_invalid,
	input wire logic cond_div_zero,
	input wire logic cond_overflow,
	input wire logic res_inexact,
	input wire logic res_tiny,
	input wire logic res_exact_zero,
	input wire logic ufm,
	output fpx_pkg::fpx_exc_t raw_exc
);

	logic uf_hit;
	logic nx_hit;

	// tininess comes in judged before rounding, whatever ufm says
	always_comb begin
		uf_hit = 1'b0;
		if (!res_exact_zero && res_tiny) begin
			if (ufm) begin
				uf_hit = 1'b1;
			end else begin
				uf_hit = res_inexact;
			end
		end
	end

	// overflow always drags inexact along
	assign nx_hit = res_inexact | cond_overflow;

	always_comb begin
		raw_exc = 5'h00;
		raw_exc[`FPX_NV_BIT] = cond_invalid;
		raw_exc[`FPX_OF_BIT] = cond_overflow;
		raw_exc[`FPX_UF_BIT] = uf_hit;
		raw_exc[`FPX_DZ_BIT] = cond_div_zero;
		raw_exc[`FPX_NX_BIT] = nx_hit;
	end

endmodule

// *** hw/fpx_exc_unit.sv ***
// Summary of operation
// - trap enable mask lives in status bits 27..23, nv of uf dz nx order.
// - current exception field lives in status bits 4..0, same bit order.
// - invalid flagged when an operand is improper for the operation.
// - overflow flagged when unbounded-exponent rounded result exceeds largest finite.
// - underflow means rounded result inexact and below smallest normalized.
// - no underflow ever when exact unrounded result is zero.
// - underflow trap disabled: tiny nonzero result plus lost accuracy signals underflow.
// - underflow trap enabled: any tiny nonzero result signals underflow.
// - tininess always judged before rounding.
// - divide-by-zero flagged when finite operands give an exact infinite result.
// - inexact flagged when rounded result differs from exact result.
// - overflow always also raises inexact.
// - mask, current and accrued fields are real hardware, ieee behaviour.
// - accrued field in status bits 9..5 gathers untrapped exceptions.
// - on normal completion mask AND new flags decides trap or accrue.
// - a trapping ieee exception leaves exactly one current bit set.
// - any other trap leaves the current field untouched.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fpx_params.svh"

module fpx_exc_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_done,
	input wire logic [2:0] op_ftt,
	input wire logic cond_invalid,
	input wire logic cond_div_zero,
	input wire logic cond_overflow,
	input wire logic res_inexact,
	input wire logic res_tiny,
	input wire logic res_exact_zero,
	output logic ieee_arith_trap,
	output logic [4:0] fp_tem,
	output logic [4:0] fp_aexc,
	output logic [4:0] fp_cexc,
	output logic [2:0] fp_ftt
);

	// fp_status_register pieces
	fpx_pkg::fpx_exc_t tem_reg;
	fpx_pkg::fpx_exc_t tem_next;
	fpx_pkg::fpx_exc_t aexc_reg;
	fpx_pkg::fpx_exc_t aexc_next;
	fpx_pkg::fpx_exc_t cexc_reg;
	fpx_pkg::fpx_exc_t cexc_next;
	fpx_pkg::fpx_ftt_t ftt_reg;
	fpx_pkg::fpx_ftt_t ftt_next;

	// bookkeeping
	fpx_pkg::fpx_cnt_t trap_cnt_reg;
	fpx_pkg::fpx_cnt_t op_cnt_reg;
	fpx_pkg::fpx_exc_t last_raw_reg;
	logic last_trap_reg;
	logic trap_reg;
	logic [31:0] prdata_reg;
	fpx_pkg::fpx_evt_t evt_cnt [5];

	// operation side
	fpx_pkg::fpx_exc_t raw_exc;
	fpx_pkg::fpx_exc_t trap_hit;
	fpx_pkg::fpx_exc_t trap_one;
	logic op_normal;
	logic op_other;
	logic op_trap;
	logic op_update;

	// bus side
	fpx_pkg::fpx_sel_t sel;
	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic wr_status;
	logic wr_traps;
	logic wr_ops;
	logic wr_cnt_lo;
	logic wr_cnt_hi;
	logic [31:0] wmask;
	logic [31:0] status_word;
	logic [31:0] status_wr;

	// raw condition evaluation
	fpx_cond_eval u_eval (
		.cond_invalid(cond_invalid),
		.cond_div_zero(cond_div_zero),
		.cond_overflow(cond_overflow),
		.res_inexact(res_inexact),
		.res_tiny(res_tiny),
		.res_exact_zero(res_exact_zero),
		.ufm(tem_reg[`FPX_UF_BIT]),
		.raw_exc(raw_exc)
	);

	// apb phases and decode
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;

	always_comb begin
		sel = fpx_pkg::SEL_NONE;
		if (paddr[1:0] == 2'h0) begin
			unique case (paddr)
				`FPX_OFF_STATUS: sel = fpx_pkg::SEL_STATUS;
				`FPX_OFF_TRAPS: sel = fpx_pkg::SEL_TRAPS;
				`FPX_OFF_OPS: sel = fpx_pkg::SEL_OPS;
				`FPX_OFF_LAST: sel = fpx_pkg::SEL_LAST;
				`FPX_OFF_CNT_LO: sel = fpx_pkg::SEL_CNT_LO;
				`FPX_OFF_CNT_HI: sel = fpx_pkg::SEL_CNT_HI;
				default: sel = fpx_pkg::SEL_NONE;
			endcase
		end
	end

	// read data is latched in setup, so access always finishes at once
	assign pready = access_ph;
	assign pslverr = access_ph & (sel == fpx_pkg::SEL_NONE);
	assign prdata = prdata_reg;

	assign wr_en = access_ph & pwrite & (sel != fpx_pkg::SEL_NONE);
	assign wr_status = wr_en & (sel == fpx_pkg::SEL_STATUS);
	assign wr_traps = wr_en & (sel == fpx_pkg::SEL_TRAPS);
	assign wr_ops = wr_en & (sel == fpx_pkg::SEL_OPS);
	assign wr_cnt_lo = wr_en & (sel == fpx_pkg::SEL_CNT_LO);
	assign wr_cnt_hi = wr_en & (sel == fpx_pkg::SEL_CNT_HI);

	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`FPX_TEM_HI:`FPX_TEM_LO] = tem_reg;
		status_word[`FPX_FTT_HI:`FPX_FTT_LO] = ftt_reg;
		status_word[`FPX_AEXC_HI:`FPX_AEXC_LO] = aexc_reg;
		status_word[`FPX_CEXC_HI:`FPX_CEXC_LO] = cexc_reg;
	end

	// byte lanes left out of the strobe keep their old value
	assign status_wr = (pwdata & wmask) | (status_word & ~wmask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			unique case (sel)
				fpx_pkg::SEL_STATUS: prdata_reg <= status_word;
				fpx_pkg::SEL_TRAPS: prdata_reg <= {16'h0000, trap_cnt_reg};
				fpx_pkg::SEL_OPS: prdata_reg <= {16'h0000, op_cnt_reg};
				fpx_pkg::SEL_LAST: prdata_reg <= {23'h000000, last_trap_reg, 3'h0, last_raw_reg};
				fpx_pkg::SEL_CNT_LO: prdata_reg <= {evt_cnt[3], evt_cnt[2], evt_cnt[1], evt_cnt[0]};
				fpx_pkg::SEL_CNT_HI: prdata_reg <= {24'h000000, evt_cnt[4]};
				fpx_pkg::SEL_NONE: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// trap decision on the completing operation
	assign op_normal = op_done & (op_ftt == `FPX_FTT_NONE);
	assign op_other = op_done & (op_ftt != `FPX_FTT_NONE);
	assign trap_hit = tem_reg & raw_exc;
	assign op_trap = op_normal & (trap_hit != 5'h00);
	assign op_update = op_normal;

	// one bit only survives a trap; overflow or underflow beat inexact
	function automatic fpx_pkg::fpx_exc_t pick_one(input fpx_pkg::fpx_exc_t hit);
		fpx_pkg::fpx_exc_t res;
		res = 5'h00;
		if (hit[`FPX_NV_BIT]) begin
			res[`FPX_NV_BIT] = 1'b1;
		end else if (hit[`FPX_DZ_BIT]) begin
			res[`FPX_DZ_BIT] = 1'b1;
		end else if (hit[`FPX_OF_BIT]) begin
			res[`FPX_OF_BIT] = 1'b1;
		end else if (hit[`FPX_UF_BIT]) begin
			res[`FPX_UF_BIT] = 1'b1;
		end else if (hit[`FPX_NX_BIT]) begin
			res[`FPX_NX_BIT] = 1'b1;
		end
		return res;
	endfunction

	assign trap_one = pick_one(trap_hit);

	// next state of the status fields; the operation outranks software on current and trap type, and ORs its flags into a written accrued field
	always_comb begin
		tem_next = tem_reg;
		aexc_next = aexc_reg;
		cexc_next = cexc_reg;
		ftt_next = ftt_reg;
		if (wr_status) begin
			tem_next = status_wr[`FPX_TEM_HI:`FPX_TEM_LO];
			aexc_next = status_wr[`FPX_AEXC_HI:`FPX_AEXC_LO];
			cexc_next = status_wr[`FPX_CEXC_HI:`FPX_CEXC_LO];
			ftt_next = status_wr[`FPX_FTT_HI:`FPX_FTT_LO];
		end
		if (op_other) begin
			ftt_next = op_ftt;
		end else if (op_trap) begin
			cexc_next = trap_one;
			ftt_next = `FPX_FTT_IEEE;
		end else if (op_update) begin
			cexc_next = raw_exc;
			aexc_next = aexc_next | raw_exc;
			ftt_next = `FPX_FTT_NONE;
		end
	end

	// trap enable mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tem_reg <= `FPX_TEM_RST;
		end else begin
			tem_reg <= tem_next;
		end
	end

	// accrued field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aexc_reg <= `FPX_AEXC_RST;
		end else begin
			aexc_reg <= aexc_next;
		end
	end

	// current field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cexc_reg <= `FPX_CEXC_RST;
		end else begin
			cexc_reg <= cexc_next;
		end
	end

	// trap type field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ftt_reg <= `FPX_FTT_RST;
		end else begin
			ftt_reg <= ftt_next;
		end
	end

	// trap request pulse, one cycle after the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_reg <= 1'b0;
		end else begin
			trap_reg <= op_trap;
		end
	end

	assign ieee_arith_trap = trap_reg;
	assign fp_tem = tem_reg;
	assign fp_aexc = aexc_reg;
	assign fp_cexc = cexc_reg;
	assign fp_ftt = ftt_reg;

	// trap and operation counters, counting beats clearing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_cnt_reg <= `FPX_CNT_RST;
		end else if (op_trap) begin
			if (wr_traps) begin
				trap_cnt_reg <= 16'h0001;
			end else if (trap_cnt_reg != `FPX_CNT_MAX) begin
				trap_cnt_reg <= trap_cnt_reg + 16'h0001;
			end
		end else if (wr_traps) begin
			trap_cnt_reg <= `FPX_CNT_RST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_cnt_reg <= `FPX_CNT_RST;
		end else if (op_normal) begin
			if (wr_ops) begin
				op_cnt_reg <= 16'h0001;
			end else if (op_cnt_reg != `FPX_CNT_MAX) begin
				op_cnt_reg <= op_cnt_reg + 16'h0001;
			end
		end else if (wr_ops) begin
			op_cnt_reg <= `FPX_CNT_RST;
		end
	end

	// unmasked conditions of the last normal completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_raw_reg <= 5'h00;
		end else if (op_normal) begin
			last_raw_reg <= raw_exc;
		end
	end

	// whether that completion trapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_trap_reg <= 1'b0;
		end else if (op_normal) begin
			last_trap_reg <= op_trap;
		end
	end

	// per-exception event counters, fed by the new current bits
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_evt
			fpx_pkg::fpx_evt_t cnt_reg;
			logic clr;
			logic hit;
			if (gi == `FPX_NV_BIT) begin : g_hi
				assign clr = wr_cnt_hi;
			end else begin : g_lo
				assign clr = wr_cnt_lo;
			end
			assign hit = op_normal & cexc_next[gi];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_reg <= `FPX_EVT_RST;
				end else if (hit) begin
					if (clr) begin
						cnt_reg <= 8'h01;
					end else if (cnt_reg != `FPX_EVT_MAX) begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end else if (clr) begin
					cnt_reg <= `FPX_EVT_RST;
				end
			end
			assign evt_cnt[gi] = cnt_reg;
		end
	endgenerate

endmodule

// *** tb/fpx_exc_unit_props.sv ***
`timescale 1ns/1ps
module fpx_exc_unit_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic op_done,
	input wire logic [2:0] op_ftt,
	input wire logic cond_invalid,
	input wire logic cond_div_zero,
	input wire logic cond_overflow,
	input wire logic res_inexact,
	input wire logic res_tiny,
	input wire logic res_exact_zero,
	input wire logic ieee_arith_trap,
	input wire logic [4:0] fp_tem,
	input wire logic [4:0] fp_aexc,
	input wire logic [4:0] fp_cexc,
	input wire logic [2:0] fp_ftt
);
	logic [4:0] raw_c;
	logic norm;
	assign raw_c = {cond_invalid, cond_overflow, ~res_exact_zero & res_tiny
		& (fp_tem[2] | res_inexact), cond_div_zero, res_inexact | cond_overflow};
	assign norm = op_done && op_ftt == 3'h0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_trap_cause: assert property (norm |=> ieee_arith_trap == |$past(fp_tem & raw_c))
		else $error("trap decision wrong");
	a_accrue_flags: assert property (norm && !(|(fp_tem & raw_c)) |=>
		fp_cexc == $past(raw_c) && fp_aexc == ($past(fp_aexc) | $past(raw_c)) && fp_ftt == 3'h0)
		else $error("untrapped flags wrong");
	a_trap_onehot: assert property (norm && |(fp_tem & raw_c) |=> $onehot(fp_cexc)
		&& (fp_cexc & ~$past(fp_tem & raw_c)) == 5'h00 && $stable(fp_aexc) && fp_ftt == 3'h1)
		else $error("trapped flags wrong");
	a_other_trap: assert property (op_done && op_ftt != 3'h0 |=> $stable(fp_cexc)
		&& $stable(fp_aexc) && !ieee_arith_trap)
		else $error("other trap touched flags");
	a_trap_origin: assert property (ieee_arith_trap |-> $past(norm))
		else $error("trap without operation");
	a_uf_zero: assert property (norm && res_exact_zero |=> !fp_cexc[2])
		else $error("underflow on exact zero");
	a_of_inexact: assert property (norm && cond_overflow && fp_tem == 5'h00 |=>
		fp_cexc[3] && fp_cexc[0])
		else $error("overflow without inexact");
	a_status_write: assert property (psel && penable && pwrite && paddr == 8'h00
		&& pstrb == 4'hF && !op_done |=> fp_tem == $past(pwdata[27:23])
		&& fp_aexc == $past(pwdata[9:5]) && fp_cexc == $past(pwdata[4:0]))
		else $error("status write lost");
endmodule
bind fpx_exc_unit fpx_exc_unit_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .op_done, .op_ftt, .cond_invalid, .cond_div_zero, .cond_overflow,
	.res_inexact, .res_tiny, .res_exact_zero, .ieee_arith_trap, .fp_tem, .fp_aexc, .fp_cexc,
	.fp_ftt);

// *** tb/fpx_fpu_model.sv ***
`timescale 1ns/1ps
module fpx_fpu_model (
	input wire logic pclk,
	output logic op_done,
	output logic [2:0] op_ftt,
	output logic cond_invalid,
	output logic cond_div_zero,
	output logic cond_overflow,
	output logic res_inexact,
	output logic res_tiny,
	output logic res_exact_zero
);
	logic [5:0] cv = 6'h00;
	assign {cond_invalid, cond_div_zero, cond_overflow, res_inexact, res_tiny, res_exact_zero} = cv;
	initial begin
		op_done = 1'b0;
		op_ftt = 3'h0;
	end
	// one completion, conditions valid with it
	task automatic issue(input logic [2:0] ftt, input logic [5:0] c);
		@(posedge pclk);
		op_done <= 1'b1;
		op_ftt <= ftt;
		cv <= c;
	endtask
	// idle: condition lines scrambled
	task automatic idle();
		@(posedge pclk);
		op_done <= 1'b0;
		op_ftt <= 3'($urandom);
		cv <= 6'($urandom);
	endtask
endmodule

// *** tb/fpx_exc_unit_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fpx_exc_unit_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_done, ieee_arith_trap, seen;
	logic cond_invalid, cond_div_zero, cond_overflow, res_inexact, res_tiny, res_exact_zero;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, st, rd;
	logic [3:0] pstrb;
	logic [2:0] op_ftt, fp_ftt;
	logic [4:0] fp_tem, fp_aexc, fp_cexc;
	logic [13:0] q[$];
	logic [13:0] ex;
	int num_checks, n_fail;
	logic [15:0] trp_cnt, ops_cnt;
	logic [31:0] last_w;
	logic [7:0] evt [5] = '{default: 8'h00};
	logic [13:0] tbl [14] = '{14'h000C, 14'h0208, 14'h100C, 14'h0006, 14'h0002, 14'h0802,
		14'h0807, 14'h0020, 14'h0010, 14'h0004, 14'h2430, 14'h3EFC, 14'h0A06, 14'h0206};
	fpx_exc_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .op_done, .op_ftt, .cond_invalid, .cond_div_zero,
		.cond_overflow, .res_inexact, .res_tiny, .res_exact_zero, .ieee_arith_trap, .fp_tem,
		.fp_aexc, .fp_cexc, .fp_ftt);
	fpx_fpu_model FPU (.pclk, .op_done, .op_ftt, .cond_invalid, .cond_div_zero,
		.cond_overflow, .res_inexact, .res_tiny, .res_exact_zero);
	always #50 pclk = ~pclk;
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_fail++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wst(input logic [31:0] d, input logic [3:0] s);
		logic e;
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h0F81C3FF;
		st = (st & ~m) | (d & m);
		apb(1'b1, 8'h00, d, s, e);
		`CHK(e, 1'b0)
	endtask
	task automatic rchk();
		logic e;
		apb(1'b0, 8'h00, 32'h0, 4'hF, e);
		`CHK(rd, st)
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] x);
		logic e;
		apb(1'b0, a, 32'h0, 4'hF, e);
		`CHK({e, rd}, {1'b0, x})
	endtask
	task automatic cnt_chk();
		rreg(8'h04, {16'h0000, trp_cnt});
		rreg(8'h08, {16'h0000, ops_cnt});
		rreg(8'h10, {evt[3], evt[2], evt[1], evt[0]});
		rreg(8'h14, {24'h000000, evt[4]});
	endtask
	task automatic op(input logic [2:0] ftt, input logic [5:0] c);
		logic [4:0] raw, hit;
		raw = {c[5], c[3], ~c[0] & c[1] & (st[25] | c[2]), c[4], c[2] | c[3]};
		hit = raw & st[27:23];
		if (ftt != 3'h0) begin
			st[16:14] = ftt;
		end else if (hit != 5'h00) begin
			st[4:0] = hit[4] ? 5'h10 : hit[1] ? 5'h02 : hit[3] ? 5'h08 : hit[2] ? 5'h04 : 5'h01;
			st[16:14] = 3'h1;
		end else begin
			st[4:0] = raw;
			st[9:5] = st[9:5] | raw;
			st[16:14] = 3'h0;
		end
		if (ftt == 3'h0) begin
			ops_cnt++;
			trp_cnt += 16'(hit != 5'h00);
			last_w = {23'h000000, hit != 5'h00, 3'h0, raw};
			for (int i = 0; i < 5; i++) begin
				evt[i] += 8'(st[i]);
			end
		end
		q.push_back({ftt == 3'h0 && hit != 5'h00, st[9:5], st[4:0], st[16:14]});
		FPU.issue(ftt, c);
	endtask
	always @(posedge pclk) begin
		if (seen && q.size() != 0) begin
			ex = q.pop_front();
			`CHK({ieee_arith_trap, fp_aexc, fp_cexc, fp_ftt}, ex)
		end
		seen = op_done === 1'b1;
	end
	initial begin
		logic e;
		{pclk, presetn, psel, penable, pwrite, seen} = 6'h00;
		{paddr, pwdata, pstrb, st} = 76'h0;
		{trp_cnt, ops_cnt, last_w} = 64'h0;
		void'($urandom(32'hF41316A3));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk();
		apb(1'b0, 8'h18, 32'h0, 4'hF, e);
		`CHK({e, rd}, 33'h100000000)
		foreach (tbl[i]) begin
			wst({4'h0, tbl[i][13:9], 18'h0, 5'($urandom)}, 4'hF);
			op(tbl[i][8:6], tbl[i][5:0]);
			FPU.idle();
			rchk();
			rreg(8'h0C, last_w);
		end
		cnt_chk();
		apb(1'b1, 8'h04, $urandom, 4'($urandom), e);
		`CHK(e, 1'b0)
		apb(1'b1, 8'h10, $urandom, 4'($urandom), e);
		`CHK(e, 1'b0)
		trp_cnt = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			evt[k] = 8'h00;
		end
		cnt_chk();
		repeat (8) begin
			wst($urandom, 4'hF);
			repeat (6) op(($urandom_range(0, 4) == 0) ? 3'h2 : 3'h0, 6'($urandom));
			FPU.idle();
			rchk();
		end
		cnt_chk();
		wst($urandom, 4'h1);
		rchk();
		`CHK(q.size(), 0)
		tally_and_finish();
	end
endmodule
